// file: gpled_defines.svh
`ifndef GPLED_DEFINES_SVH
`define GPLED_DEFINES_SVH

// Register map, byte addresses on the AXI4-Lite port
`define GPLED_AW           8
`define GPLED_OFS_DATA_DIR 8'h00
`define GPLED_OFS_CFG      8'h04
`define GPLED_OFS_IRQ      8'h08
`define GPLED_OFS_LED_CFG  8'h0c
`define GPLED_OFS_GLB_IRQ  8'h10

// Field layout: low field in [5:0], high field from this bit up
`define GPLED_HI_LSB       8
`define GPLED_NPINS        6

// Reset values
`define GPLED_RST_PINS     6'h00
`define GPLED_RST_FUN      2'h0

// Bus responses
`define GPLED_RESP_OKAY    2'h0
`define GPLED_RESP_SLVERR  2'h2

// Indication stretch time and clock rate
`define GPLED_STRETCH_MS   80
`define GPLED_CLK_KHZ      250000
`define GPLED_CNT_W        25
`define GPLED_NSTR         9

`endif

// file: gpled_pkg.sv
`include "gpled_defines.svh"

package gpled_pkg;

	// Stretcher phases, one-hot
	typedef enum logic [2:0] {
		GPLED_ST_IDLE = 3'h1,
		GPLED_ST_ON   = 3'h2,
		GPLED_ST_OFF  = 3'h4
	} gpled_st_t;

	// LED function codes
	typedef enum logic [1:0] {
		GPLED_FUN_LINK = 2'h0,
		GPLED_FUN_SPLIT = 2'h1,
		GPLED_FUN_TXRX = 2'h2,
		GPLED_FUN_RAW  = 2'h3
	} gpled_fun_t;

	typedef struct packed {
		gpled_st_t              st;
		logic [`GPLED_CNT_W-1:0] cnt;
	} gpled_str_state_t;

	typedef struct packed {
		logic                   awrdy;
		logic                   wrdy;
		logic                   arrdy;
		logic [`GPLED_AW-1:0]   awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rd_pend;
		logic [`GPLED_AW-1:0]   araddr;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} gpled_axil_state_t;

	typedef struct packed {
		logic [19:0] s1;
		logic [19:0] s2;
		logic [1:0]  ld;
		logic [5:0]  data;
		logic [5:0]  dir;
		logic [5:0]  buft;
		logic [5:0]  pol;
		logic [5:0]  ists;
		logic [5:0]  ien;
		logic [5:0]  led_en;
		gpled_fun_t  fun;
		logic [5:0]  led_pol;
		logic [5:0]  pout;
		logic [5:0]  poe;
		logic [5:0]  ibuf;
		logic        irq;
	} gpled_top_state_t;

endpackage : gpled_pkg

// file: gpled_stretch.sv
`timescale 1ns/10ps
`include "gpled_defines.svh"

module gpled_stretch #(
	parameter logic [`GPLED_CNT_W-1:0] LEN = `GPLED_CNT_W'(20000000)
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic trig_in,
	output logic      on_out
);

	gpled_pkg::gpled_str_state_t st_reg;
	gpled_pkg::gpled_str_state_t st_next;

	// Pulse for LEN cycles, then hold off for LEN cycles
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg.st)
			gpled_pkg::GPLED_ST_IDLE:
				if (trig_in)
				begin
					st_next.st = gpled_pkg::GPLED_ST_ON; // [R18]
					st_next.cnt = LEN - `GPLED_CNT_W'(1);
				end
			gpled_pkg::GPLED_ST_ON:
				if (st_reg.cnt == '0)
				begin
					st_next.st = gpled_pkg::GPLED_ST_OFF; // [R18]
					st_next.cnt = LEN - `GPLED_CNT_W'(1);
				end
				else
					st_next.cnt = st_reg.cnt - `GPLED_CNT_W'(1);
			gpled_pkg::GPLED_ST_OFF:
				if (st_reg.cnt == '0)
					st_next.st = gpled_pkg::GPLED_ST_IDLE;
				else
					st_next.cnt = st_reg.cnt - `GPLED_CNT_W'(1);
			default:
				st_next.st = gpled_pkg::GPLED_ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= '{st: gpled_pkg::GPLED_ST_IDLE, cnt: '0};
		else
			st_reg <= st_next;
	end

	assign on_out = (st_reg.st == gpled_pkg::GPLED_ST_ON);

	// Checks on the stretch sequence
	sequence s_start;
		(st_reg.st == gpled_pkg::GPLED_ST_IDLE) && trig_in;
	endsequence

	property p_start;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_start |=> (on_out && st_reg.cnt == LEN - `GPLED_CNT_W'(1));
	endproperty
	a_start: assert property (p_start) // [R18]
		else $error("stretch did not start on traffic");

	property p_on_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		(on_out && st_reg.cnt != '0) |=> on_out;
	endproperty
	a_on_hold: assert property (p_on_hold) // [R18]
		else $error("active pulse ended early");

	property p_off_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_reg.st == gpled_pkg::GPLED_ST_OFF && st_reg.cnt != '0)
			|=> !on_out;
	endproperty
	a_off_hold: assert property (p_off_hold) // [R18]
		else $error("inactive gap cut short");

endmodule : gpled_stretch

// file: gpled_axil.sv
`timescale 1ns/10ps
`include "gpled_defines.svh"

module gpled_axil (
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	input  wire logic [`GPLED_AW-1:0] s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [`GPLED_AW-1:0] s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	output logic                      wr_en_out,
	output logic [`GPLED_AW-1:0]      wr_addr_out,
	output logic [31:0]               wr_data_out,
	output logic [3:0]                wr_strb_out,
	input  wire logic                 wr_err_in,
	output logic                      rd_en_out,
	output logic [`GPLED_AW-1:0]      rd_addr_out,
	input  wire logic [31:0]          rd_data_in,
	input  wire logic                 rd_err_in
);

	localparam gpled_pkg::gpled_axil_state_t RST =
		'{awrdy: 1'h1, wrdy: 1'h1, arrdy: 1'h1, default: '0};

	gpled_pkg::gpled_axil_state_t st_reg;
	gpled_pkg::gpled_axil_state_t st_next;
	logic                         wr_go;

	// Write fires once address and data are both held
	assign wr_go = !st_reg.awrdy && !st_reg.wrdy && !st_reg.bvalid;

	// Channel handshakes
	always_comb
	begin
		st_next = st_reg;
		if (s_axi_awvalid_in && st_reg.awrdy)
		begin
			st_next.awrdy = 1'h0;
			st_next.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && st_reg.wrdy)
		begin
			st_next.wrdy = 1'h0;
			st_next.wdata = s_axi_wdata_in;
			st_next.wstrb = s_axi_wstrb_in;
		end
		if (wr_go)
		begin
			st_next.bvalid = 1'h1;
			st_next.bresp = wr_err_in ? `GPLED_RESP_SLVERR
				: `GPLED_RESP_OKAY;
		end
		if (st_reg.bvalid && s_axi_bready_in)
		begin
			st_next.bvalid = 1'h0;
			st_next.awrdy = 1'h1;
			st_next.wrdy = 1'h1;
		end
		if (s_axi_arvalid_in && st_reg.arrdy)
		begin
			st_next.arrdy = 1'h0;
			st_next.araddr = s_axi_araddr_in;
			st_next.rd_pend = 1'h1;
		end
		if (st_reg.rd_pend)
		begin
			st_next.rd_pend = 1'h0;
			st_next.rvalid = 1'h1;
			st_next.rdata = rd_data_in;
			st_next.rresp = rd_err_in ? `GPLED_RESP_SLVERR
				: `GPLED_RESP_OKAY;
		end
		if (st_reg.rvalid && s_axi_rready_in)
		begin
			st_next.rvalid = 1'h0;
			st_next.arrdy = 1'h1;
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_reg <= RST;
		else
			st_reg <= st_next;
	end

	// Bus and register-side outputs
	assign s_axi_awready_out = st_reg.awrdy;
	assign s_axi_wready_out  = st_reg.wrdy;
	assign s_axi_bvalid_out  = st_reg.bvalid;
	assign s_axi_bresp_out   = st_reg.bresp;
	assign s_axi_arready_out = st_reg.arrdy;
	assign s_axi_rvalid_out  = st_reg.rvalid;
	assign s_axi_rdata_out   = st_reg.rdata;
	assign s_axi_rresp_out   = st_reg.rresp;
	assign wr_en_out         = wr_go;
	assign wr_addr_out       = st_reg.awaddr;
	assign wr_data_out       = st_reg.wdata;
	assign wr_strb_out       = st_reg.wstrb;
	assign rd_en_out         = st_reg.rd_pend;
	assign rd_addr_out       = st_reg.araddr;

endmodule : gpled_axil

// file: gpled_top.sv
`timescale 1ns/10ps
`include "gpled_defines.svh"

// Overview of operation
// [R1] Six pins: input, push-pull, open-drain, interrupt
// [R2] Reset clears all direction bits: inputs
// [R3] Reset clears all pin interrupt enables
// [R4] Reset clears polarity: low-level interrupt trigger
// [R5] Buffer-type bit picks push-pull or open-drain
// [R6] Open-drain: data 0 drives low, 1 floats
// [R7] Push-pull drives the data bit level
// [R8] Input pin data read returns sampled level
// [R9] Per-pin status bit plus separate enable bit
// [R10] Enabled statuses ORed into global pin event
// [R11] Polarity set: high sets status; else low
// [R12] LED enable: LED output, input buffer off
// [R13] LED enable, function, polarity from straps
// [R14] Function 00b pin mapping
// [R15] Function 01b pin mapping
// [R16] Function 10b pin mapping
// [R17] Active drives inverse polarity; inactive floats
// [R18] Activity pulses 80ms, then 80ms minimum off
// [R19] Link/activity: steady link, 80ms dark blink
// [R20] Function 11b: push-pull raw frame enables
// [R21] LED mode overrides general-purpose pin settings
// [R22] Interrupt compare uses synchronised pin copy

module gpled_top #(
	parameter int unsigned STRETCH_CYCLES =
		`GPLED_STRETCH_MS * `GPLED_CLK_KHZ
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_b_in,
	input  wire logic [`GPLED_AW-1:0] s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [`GPLED_AW-1:0] s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	input  wire logic [5:0]           pin_lvl_in,
	output logic [5:0]                pin_drive_out,
	output logic [5:0]                pin_oe_out,
	output logic [5:0]                pin_ibuf_en_out,
	output logic                      pin_irq_out,
	input  wire logic [5:0]           led_en_strap_in,
	input  wire logic [1:0]           led_fun_strap_in,
	input  wire logic [5:0]           led_pol_strap_in,
	input  wire logic                 port1_phy_en_in,
	input  wire logic [2:1]           port_link_in,
	input  wire logic [2:1]           port_spd100_in,
	input  wire logic [2:1]           port_fdx_in,
	input  wire logic [2:1]           port_col_in,
	input  wire logic [2:0]           mii_tx_en_in,
	input  wire logic [2:0]           mii_rx_dv_in
);

	logic                         rst_meta_reg;
	logic                         rst_n;
	gpled_pkg::gpled_top_state_t  st_reg;
	gpled_pkg::gpled_top_state_t  st_next;
	logic                         wr_en;
	logic [`GPLED_AW-1:0]         wr_addr;
	logic [31:0]                  wr_data;
	logic [3:0]                   wr_strb;
	logic                         wr_err;
	logic                         rd_en;
	logic [`GPLED_AW-1:0]         rd_addr;
	logic [31:0]                  rd_data;
	logic                         rd_err;
	logic [`GPLED_NSTR-1:0]       trig;
	logic [`GPLED_NSTR-1:0]       strd;
	logic [2:1]                   la;
	logic [2:1]                   dc;
	logic [2:1]                   sp;
	logic [2:1]                   l100;
	logic [2:1]                   l10;
	logic [5:0]                   led_func;
	logic [5:0]                   pin_rd;
	logic                         irq_src;

	// Reset release through two flip-flops
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta_reg <= 1'h0;
			rst_n <= 1'h0;
		end
		else
		begin
			rst_meta_reg <= 1'h1;
			rst_n <= rst_meta_reg;
		end
	end

	gpled_axil u_axil (
		.clk_in            (core_clk_in),
		.rst_n_in          (rst_n),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.wr_en_out         (wr_en),
		.wr_addr_out       (wr_addr),
		.wr_data_out       (wr_data),
		.wr_strb_out       (wr_strb),
		.wr_err_in         (wr_err),
		.rd_en_out         (rd_en),
		.rd_addr_out       (rd_addr),
		.rd_data_in        (rd_data),
		.rd_err_in         (rd_err)
	);

	// Traffic and collision sources to stretch
	assign trig = {port_col_in[2], port_col_in[1],
		mii_tx_en_in[2] | mii_rx_dv_in[2],
		mii_tx_en_in[1] | mii_rx_dv_in[1],
		mii_tx_en_in[0] | mii_rx_dv_in[0],
		mii_rx_dv_in[1], mii_tx_en_in[1],
		mii_rx_dv_in[0], mii_tx_en_in[0]};

	genvar gi;
	generate
		for (gi = 0; gi < `GPLED_NSTR; gi++)
		begin : g_str
			gpled_stretch #(
				.LEN (`GPLED_CNT_W'(STRETCH_CYCLES))
			) u_str (
				.clk_in   (core_clk_in),
				.rst_n_in (rst_n),
				.trig_in  (trig[gi]),
				.on_out   (strd[gi])
			);
		end
	endgenerate

	// Per-port indications
	always_comb
	begin
		for (int p = 1; p <= 2; p++)
		begin
			la[p] = port_link_in[p] && !strd[4 + p]; // [R19]
			dc[p] = port_link_in[p] && (port_fdx_in[p] || strd[6 + p]);
			sp[p] = port_link_in[p] && port_spd100_in[p];
			l100[p] = la[p] && port_spd100_in[p]; // [R19]
			l10[p] = la[p] && !port_spd100_in[p]; // [R19]
		end
	end

	// Function-code pin mapping
	always_comb
	begin
		unique case (st_reg.fun)
			gpled_pkg::GPLED_FUN_LINK: // [R14]
				led_func = {la[2], dc[2], sp[2],
					port1_phy_en_in ? la[1] : strd[5],
					port1_phy_en_in ? dc[1] : 1'h0,
					port1_phy_en_in ? sp[1] : strd[4]};
			gpled_pkg::GPLED_FUN_SPLIT: // [R15]
				led_func = {l100[2], dc[2], l10[2],
					port1_phy_en_in ? l100[1] : strd[5],
					port1_phy_en_in ? dc[1] : 1'h0,
					port1_phy_en_in ? l10[1] : strd[4]};
			gpled_pkg::GPLED_FUN_TXRX: // [R16]
				led_func = {strd[0], la[2], sp[2], strd[1],
					port1_phy_en_in ? la[1] : strd[2],
					port1_phy_en_in ? sp[1] : strd[3]};
			gpled_pkg::GPLED_FUN_RAW: // [R20]
				led_func = {mii_tx_en_in[0], mii_tx_en_in[2],
					mii_rx_dv_in[2], mii_rx_dv_in[0],
					mii_tx_en_in[1], mii_rx_dv_in[1]};
		endcase
	end

	// Register read mux and decode
	assign irq_src = |(st_reg.ists & st_reg.ien); // [R10]
	assign pin_rd = ((st_reg.dir | st_reg.led_en) & st_reg.data)
		| (~(st_reg.dir | st_reg.led_en) & st_reg.s2[5:0]); // [R8]
	always_comb
	begin
		rd_err = 1'h0;
		unique case (rd_addr)
			`GPLED_OFS_DATA_DIR: rd_data = {18'h0, st_reg.dir, 2'h0, pin_rd};
			`GPLED_OFS_CFG: rd_data = {18'h0, st_reg.pol, 2'h0, st_reg.buft};
			`GPLED_OFS_IRQ: rd_data = {18'h0, st_reg.ien, 2'h0, st_reg.ists};
			`GPLED_OFS_LED_CFG:
				rd_data = {22'h0, st_reg.fun, 2'h0, st_reg.led_en};
			`GPLED_OFS_GLB_IRQ: rd_data = {31'h0, st_reg.irq}; // [R10]
			default:
			begin
				rd_data = 32'h0;
				rd_err = 1'h1;
			end
		endcase
	end
	assign wr_err = !(wr_addr inside {`GPLED_OFS_DATA_DIR, `GPLED_OFS_CFG,
		`GPLED_OFS_IRQ, `GPLED_OFS_LED_CFG, `GPLED_OFS_GLB_IRQ});

	// Next state: sync, straps, registers, pin drive
	always_comb
	begin
		st_next = st_reg;
		st_next.s1 = {led_pol_strap_in, led_fun_strap_in, led_en_strap_in,
			pin_lvl_in};
		st_next.s2 = st_reg.s1; // [R22]
		if (st_reg.ld != 2'h3)
			st_next.ld = st_reg.ld + 2'h1;
		if (st_reg.ld == 2'h2)
		begin
			st_next.led_en = st_reg.s2[11:6]; // [R13]
			st_next.fun = gpled_pkg::gpled_fun_t'(st_reg.s2[13:12]);
			st_next.led_pol = st_reg.s2[19:14];
		end
		if (wr_en && wr_strb[0])
			unique case (wr_addr)
				`GPLED_OFS_DATA_DIR: st_next.data = wr_data[5:0];
				`GPLED_OFS_CFG: st_next.buft = wr_data[5:0];
				`GPLED_OFS_IRQ: st_next.ists = st_reg.ists & ~wr_data[5:0];
				`GPLED_OFS_LED_CFG: st_next.led_en = wr_data[5:0];
				default: ;
			endcase
		if (wr_en && wr_strb[1])
			unique case (wr_addr)
				`GPLED_OFS_DATA_DIR: st_next.dir = wr_data[13:8];
				`GPLED_OFS_CFG: st_next.pol = wr_data[13:8];
				`GPLED_OFS_IRQ: st_next.ien = wr_data[13:8]; // [R9]
				`GPLED_OFS_LED_CFG:
					st_next.fun = gpled_pkg::gpled_fun_t'(wr_data[9:8]);
				default: ;
			endcase
		for (int i = 0; i < `GPLED_NPINS; i++) // [R1]
		begin
			// Level match sets status once the synchroniser holds real
			// pin levels; set wins over clear
			if (st_reg.ld[1] && !st_reg.led_en[i]
				&& st_reg.s2[i] == st_reg.pol[i])
				st_next.ists[i] = 1'h1; // [R11] [R9] [R22]
			if (st_reg.led_en[i]) // [R21]
			begin
				st_next.ibuf[i] = 1'h0; // [R12]
				if (st_reg.fun == gpled_pkg::GPLED_FUN_RAW)
				begin
					st_next.poe[i] = 1'h1; // [R20]
					st_next.pout[i] = led_func[i];
				end
				else
				begin
					st_next.poe[i] = led_func[i]; // [R17]
					st_next.pout[i] = !st_reg.led_pol[i];
				end
			end
			else
			begin
				st_next.ibuf[i] = 1'h1;
				if (!st_reg.dir[i])
				begin
					st_next.poe[i] = 1'h0;
					st_next.pout[i] = 1'h0;
				end
				else if (st_reg.buft[i]) // [R5]
				begin
					st_next.poe[i] = 1'h1; // [R7]
					st_next.pout[i] = st_reg.data[i];
				end
				else
				begin
					st_next.poe[i] = !st_reg.data[i]; // [R6]
					st_next.pout[i] = 1'h0;
				end
			end
		end
		st_next.irq = irq_src; // [R10]
	end

	// State register; reset clears direction, enables, polarity
	always_ff @(posedge core_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '{fun: gpled_pkg::GPLED_FUN_LINK, ibuf: 6'h3f,
				default: '0}; // [R2] [R3] [R4]
		else
			st_reg <= st_next;
	end

	assign pin_drive_out   = st_reg.pout;
	assign pin_oe_out      = st_reg.poe;
	assign pin_ibuf_en_out = st_reg.ibuf;
	assign pin_irq_out     = st_reg.irq;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n);

	property p_dir_rst;
		$rose(rst_n) |-> st_reg.dir == `GPLED_RST_PINS;
	endproperty
	a_dir_rst: assert property (p_dir_rst) // [R2]
		else $error("direction not cleared by reset");

	property p_ien_rst;
		$rose(rst_n) |-> st_reg.ien == `GPLED_RST_PINS;
	endproperty
	a_ien_rst: assert property (p_ien_rst) // [R3]
		else $error("interrupt enables not cleared by reset");

	property p_pol_rst;
		$rose(rst_n) |-> st_reg.pol == `GPLED_RST_PINS;
	endproperty
	a_pol_rst: assert property (p_pol_rst) // [R4]
		else $error("polarity not cleared by reset");

	property p_irq;
		irq_src |=> pin_irq_out;
	endproperty
	a_irq: assert property (p_irq) // [R10]
		else $error("enabled pin status did not raise request");

	property p_strap;
		(st_reg.ld == 2'h2) |=> st_reg.led_en == $past(st_reg.s2[11:6]);
	endproperty
	a_strap: assert property (p_strap) // [R13]
		else $error("LED enables not loaded from straps");

	generate
		for (gi = 0; gi < `GPLED_NPINS; gi++)
		begin : g_chk
			property p_od;
				(!st_reg.led_en[gi] && st_reg.dir[gi] && !st_reg.buft[gi])
					|=> (!pin_drive_out[gi]
					&& pin_oe_out[gi] == !$past(st_reg.data[gi]));
			endproperty
			a_od: assert property (p_od) // [R6]
				else $error("open-drain drive wrong");

			property p_pp;
				(!st_reg.led_en[gi] && st_reg.dir[gi] && st_reg.buft[gi])
					|=> (pin_oe_out[gi]
					&& pin_drive_out[gi] == $past(st_reg.data[gi]));
			endproperty
			a_pp: assert property (p_pp) // [R7]
				else $error("push-pull drive wrong");

			property p_lvl;
				(st_reg.ld[1] && !st_reg.led_en[gi]
					&& st_reg.s2[gi] == st_reg.pol[gi])
					|=> st_reg.ists[gi];
			endproperty
			a_lvl: assert property (p_lvl) // [R11]
				else $error("level did not set pin status");

			property p_led;
				(st_reg.led_en[gi] && st_reg.fun != gpled_pkg::GPLED_FUN_RAW)
					|=> (pin_oe_out[gi] == $past(led_func[gi])
					&& pin_drive_out[gi] == !$past(st_reg.led_pol[gi])
					&& !pin_ibuf_en_out[gi]);
			endproperty
			a_led: assert property (p_led) // [R17]
				else $error("LED pin drive wrong");

			property p_raw;
				(st_reg.led_en[gi] && st_reg.fun == gpled_pkg::GPLED_FUN_RAW)
					|=> (pin_oe_out[gi]
					&& pin_drive_out[gi] == $past(led_func[gi]));
			endproperty
			a_raw: assert property (p_raw) // [R20]
				else $error("raw LED pin drive wrong");
		end
	endgenerate

endmodule : gpled_top

// file: gpled_board.sv
`timescale 1ns/10ps

// Board side of the six pins: pull-ups and optional external drivers
module gpled_board (
	input  wire logic [5:0] oe_in,
	input  wire logic [5:0] drive_in,
	input  wire logic [5:0] ext_en_in,
	input  wire logic [5:0] ext_lvl_in,
	output logic [5:0]      lvl_out
);
	// Released pins take the external level where enabled, else float to the pull-up level
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			lvl_out[i] = oe_in[i] ? drive_in[i] :
				(ext_en_in[i] ? ext_lvl_in[i] : 1'b1);
	end
endmodule : gpled_board

// file: tb_top.sv
`timescale 1ns/10ps

module tb_top;
	logic        clk = 0, rst_b = 0, phy = 1;
	logic [7:0]  aw_a = '0, ar_a = '0;
	logic [31:0] w_d = '0, r_d, d;
	logic        aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0;
	logic        aw_r, w_r, b_v, ar_r, r_v, irq;
	logic [1:0]  b_rsp, r_rsp, rs;
	logic [5:0]  lvl, drv, oe, ibuf, v, ext_en = '0, ext_lvl = '0;
	logic [2:1]  link = '0, spd = '0, fdx = '0, col = '0;
	logic [2:0]  tx = '0, rx = '0;
	logic [8:0]  tbl [4] = '{9'h12e, 9'h163, 9'h19a, 9'h028};
	int          miscompares = 0, checks_done = 0, cyc = 0;

	// Device under test with short indication stretch
	gpled_top #(.STRETCH_CYCLES(8)) dut_u (
		.core_clk_in(clk), .rst_b_in(rst_b),
		.s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
		.s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d),
		.s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(w_r), .s_axi_bresp_out(b_rsp),
		.s_axi_bvalid_out(b_v), .s_axi_bready_in(b_rdy),
		.s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
		.s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d),
		.s_axi_rresp_out(r_rsp), .s_axi_rvalid_out(r_v),
		.s_axi_rready_in(r_rdy), .pin_lvl_in(lvl), .pin_drive_out(drv),
		.pin_oe_out(oe), .pin_ibuf_en_out(ibuf), .pin_irq_out(irq),
		.led_en_strap_in(6'h00), .led_fun_strap_in(2'h2),
		.led_pol_strap_in(6'h2a), .port1_phy_en_in(phy),
		.port_link_in(link), .port_spd100_in(spd), .port_fdx_in(fdx),
		.port_col_in(col), .mii_tx_en_in(tx), .mii_rx_dv_in(rx));

	// Pins with pull-ups and external drivers
	gpled_board board_u (.oe_in(oe), .drive_in(drv), .ext_en_in(ext_en),
		.ext_lvl_in(ext_lvl), .lvl_out(lvl));

	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk

	// Write: both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		aw_a <= a;
		w_d <= x;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		do
		begin
			@(posedge clk);
			if (aw_r) aw_v <= 1'b0;
			if (w_r) w_v <= 1'b0;
		end while (!b_v);
		b_rdy <= 1'b0;
		rs = b_rsp;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		do
		begin
			@(posedge clk);
			if (ar_r) ar_v <= 1'b0;
		end while (!r_v);
		d = r_d;
		rs = r_rsp;
		r_rdy <= 1'b0;
		@(posedge clk);
	endtask : rd

	// Two traffic pulses, the second inside the stretcher's hold-off window
	task automatic strch(input logic [2:0] t, input logic a);
		int n = 0;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge clk);
			tx <= (i == 0 || i == 12) ? t : 3'h0;
			n += int'(oe[5] === a);
		end
		chk(32'(n), 32'd8);
	endtask : strch

	// Main sequence
	initial
	begin
		void'($urandom(14));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h00);
		chk(d, 32'h3f);
		rd(8'h04);
		chk(d, 32'h0);
		rd(8'h08);
		chk(d, 32'h0);
		rd(8'h0c);
		chk(d, 32'h0200);
		wr(8'h14, 32'h3f00);
		chk(32'(rs), 32'h2);
		chk(32'(oe), 32'h0);
		rd(8'h14);
		chk(32'(rs), 32'h2);
		for (int k = 0; k < 2; k++)
		begin
			v = 6'($urandom);
			wr(8'h04, k ? 32'h3f : 32'h0);
			wr(8'h00, {18'h0, 6'h3f, 2'h0, v});
			repeat (2) @(posedge clk);
			chk(32'(oe), {26'h0, (k ? 6'h3f : ~v)});
			chk(32'(drv), 32'(k ? v : 6'h0));
			chk(32'(lvl), 32'(v));
		end
		wr(8'h00, 32'h0);
		v = 6'($urandom);
		ext_en <= 6'h3f;
		ext_lvl <= v;
		repeat (4) @(posedge clk);
		rd(8'h00);
		chk(d, 32'(v));
		ext_lvl <= 6'h21;
		repeat (4) @(posedge clk);
		wr(8'h04, 32'h3f00);
		wr(8'h08, 32'h013f);
		chk(32'(rs), 32'h0);
		repeat (6) @(posedge clk);
		rd(8'h08);
		chk(d, 32'h0121);
		chk(32'(irq), 32'h1);
		rd(8'h10);
		chk(d, 32'h1);
		wr(8'h08, 32'h0200);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		ext_lvl <= 6'h00;
		wr(8'h04, 32'h0);
		repeat (6) @(posedge clk);
		chk(32'(irq), 32'h1);
		ext_lvl <= 6'h3f;
		repeat (5) @(posedge clk);
		wr(8'h08, 32'h023f);
		repeat (2) @(posedge clk);
		rd(8'h08);
		chk(d, 32'h0200);
		chk(32'(irq), 32'h0);
		ext_en <= 6'h00;
		link <= 2'b11;
		spd <= 2'b10;
		fdx <= 2'b01;
		wr(8'h04, 32'h3f);
		wr(8'h00, 32'h3f00);
		for (int i = 0; i < 4; i++)
		begin
			phy <= tbl[i][8];
			wr(8'h0c, {22'h0, tbl[i][7:6], 8'h3f});
			repeat (3) @(posedge clk);
			chk(32'(oe), 32'(tbl[i][5:0]));
			chk(32'(drv), {26'h0, ~6'h2a});
		end
		wr(8'h0c, 32'h033f);
		for (int i = 0; i < 4; i++)
		begin
			tx <= 3'($urandom);
			rx <= 3'($urandom);
			repeat (3) @(posedge clk);
			chk(32'(drv), 32'({tx[0], tx[2], rx[2], rx[0], tx[1], rx[1]}));
			chk(32'({oe, ibuf}), 32'h0fc0);
		end
		tx <= 3'h0;
		rx <= 3'h0;
		phy <= 1'b0;
		wr(8'h0c, 32'h023f);
		repeat (20) @(posedge clk);
		strch(3'h1, 1'b1);
		phy <= 1'b1;
		wr(8'h0c, 32'h003f);
		repeat (20) @(posedge clk);
		strch(3'h4, 1'b0);
		end_sim();
	end
endmodule : tb_top
